//--- src/ddi_pkg.sv
package ddi_pkg;

	localparam logic [7:0] DEV_ADDR  = 8'he0;
	localparam logic [7:0] PRE_FIRST = 8'h26;
	localparam logic [7:0] PRE_SECND = 8'h38;
	localparam logic [7:0] REG_ADDR  = 8'h65;
	localparam logic [7:0] CMD_HEAD  = 8'h16;
	localparam logic [7:0] CMD_FILL  = 8'h00;
	localparam logic [7:0] MODE_OFF  = 8'h00;
	localparam logic [7:0] MODE_ON   = 8'h01;

	localparam logic [3:0] BIT_LAST  = 4'h7;
	localparam logic [3:0] BIT_ACK   = 4'h8;
	localparam logic [3:0] IDX_MODE  = 4'h9;
	localparam logic [3:0] NUM_BYTES = 4'ha;

	localparam logic       DEMO_RST  = 1'b0;

	typedef enum logic [0:0] {
		BUS_IDLE  = 1'b0,
		BUS_FRAME = 1'b1
	} ddi_bus_t;

	// Fixed byte expected at each position ahead of the mode byte
	function automatic logic [7:0] exp_byte(input logic [3:0] idx);
		unique case (idx)
			4'h0:    exp_byte = DEV_ADDR;
			4'h1:    exp_byte = PRE_FIRST;
			4'h2:    exp_byte = PRE_SECND;
			4'h3:    exp_byte = REG_ADDR;
			4'h4:    exp_byte = CMD_HEAD;
			default: exp_byte = CMD_FILL;
		endcase
	endfunction

endpackage

//--- src/ddi_link.sv
`timescale 1ns/100ps
`default_nettype none

module ddi_link (
	input  wire logic i_scl,
	input  wire logic i_clr_n,
	input  wire logic i_sda,
	output var  logic o_sda_oe_n,
	output var  logic o_done,
	output var  logic o_mode_on
);

	logic [3:0] bit_cnt_q;
	logic [6:0] shift_q;
	logic [3:0] idx_q;
	logic       ok_q;
	logic       mode_q;
	logic       done_q;
	logic       oe_n_q;

	wire logic [7:0] byte_w    = {shift_q, i_sda};
	wire logic       last_bit  = (bit_cnt_q == ddi_pkg::BIT_LAST);
	wire logic       ack_bit   = (bit_cnt_q == ddi_pkg::BIT_ACK);
	wire logic       is_mode   = (idx_q == ddi_pkg::IDX_MODE);
	wire logic       mode_ok   = (byte_w == ddi_pkg::MODE_OFF) || (byte_w == ddi_pkg::MODE_ON);
	wire logic       fixed_ok  = (idx_q < ddi_pkg::IDX_MODE) && (byte_w == ddi_pkg::exp_byte(idx_q));
	wire logic       match     = is_mode ? mode_ok : fixed_ok;
	wire logic [3:0] idx_inc   = (idx_q == ddi_pkg::NUM_BYTES) ? idx_q : idx_q + 4'h1;

	////////////////////////////////////////////////////////////////////////
	// Data is sampled on the bus clock itself, the way the protocol defines it
	always_ff @(posedge i_scl or negedge i_clr_n) begin
		if (!i_clr_n) begin
			bit_cnt_q <= 4'h0;
			shift_q   <= 7'h00;
			idx_q     <= 4'h0;
			ok_q      <= 1'b1;
			mode_q    <= ddi_pkg::DEMO_RST;
			done_q    <= 1'b0;
		end else if (ack_bit) begin
			bit_cnt_q <= 4'h0;
			idx_q     <= idx_inc;
			done_q    <= ok_q && is_mode;
		end else begin
			bit_cnt_q <= bit_cnt_q + 4'h1;
			shift_q   <= byte_w[6:0];
			if (last_bit) begin
				ok_q <= ok_q && match;
				if (!match) begin
					done_q <= 1'b0;
				end
				if (is_mode) begin
					mode_q <= i_sda;
				end
			end
		end
	end

	// Acknowledge driven from falling edge so data is settled before high
	always_ff @(negedge i_scl or negedge i_clr_n) begin
		if (!i_clr_n) begin
			oe_n_q <= 1'b1;
		end else begin
			oe_n_q <= !(ack_bit && ok_q);
		end
	end

	assign o_sda_oe_n = oe_n_q;
	assign o_done     = done_q;
	assign o_mode_on  = mode_q;

	////////////////////////////////////////////////////////////////////////
	sequence s_byte_end;
		last_bit;
	endsequence

	property p_addr_reject;
		@(posedge i_scl) disable iff (!i_clr_n)
		s_byte_end and (idx_q == 4'h0) and (byte_w != ddi_pkg::DEV_ADDR) |=> !ok_q;
	endproperty
	a_addr_reject: assert property (p_addr_reject) else $error("Foreign address kept");

	property p_pre_reject;
		@(posedge i_scl) disable iff (!i_clr_n)
		s_byte_end and (idx_q == 4'h2) and (byte_w != ddi_pkg::PRE_SECND) |=> ##9 !done_q;
	endproperty
	a_pre_reject: assert property (p_pre_reject) else $error("Bad preamble accepted");

	property p_cmd_reject;
		@(posedge i_scl) disable iff (!i_clr_n)
		s_byte_end and (idx_q == 4'h4) and (byte_w != ddi_pkg::CMD_HEAD) |=> !ok_q;
	endproperty
	a_cmd_reject: assert property (p_cmd_reject) else $error("Bad command head kept");

	property p_ack_low;
		@(posedge i_scl) disable iff (!i_clr_n)
		s_byte_end and ok_q and match and (idx_q < ddi_pkg::NUM_BYTES) |=> !oe_n_q;
	endproperty
	a_ack_low: assert property (p_ack_low) else $error("Valid byte not acknowledged");

endmodule

`default_nettype wire

//--- src/ddi_demo_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Transaction opens START then address 0xe0
// - Preamble 0x26 then 0x38 required next
// - Register 0x65, command 0x16, four zeros
// - Sixth command byte 0x00 turns demo off
// - Sixth command byte 0x01 turns demo on
// - Demo effect only on right half

module ddi_demo_ctrl #(
	parameter int COL_W = 12
) (
	input  wire logic             i_clk_sys,
	input  wire logic             i_arst_n,
	input  wire logic             i_scl,
	input  wire logic             i_sda_i,
	output var  logic             o_sda_o,
	output var  logic             o_sda_oe_n,
	input  wire logic [COL_W-1:0] i_px_col,
	input  wire logic [COL_W-1:0] i_px_width,
	output var  logic             o_demo_on,
	output var  logic             o_demo_apply
);

	logic             rst_meta_q;
	logic             rst_n_q;
	logic             scl_meta_q;
	logic             scl_s_q;
	logic             scl_d_q;
	logic             sda_meta_q;
	logic             sda_s_q;
	logic             sda_d_q;
	logic             done_meta_q;
	logic             done_s_q;
	logic             mode_meta_q;
	logic             mode_s_q;
	logic             link_clr_n_q;
	logic             link_clr_n_d;
	logic             demo_on_q;
	logic             apply_q;
	logic             sda_o_q;
	ddi_pkg::ddi_bus_t state_q;
	ddi_pkg::ddi_bus_t state_d;
	logic             link_done;
	logic             link_mode;
	logic             link_oe_n;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end


	////////////////////////////////////////////////////////////////////////
	// Line events seen from the system clock; both pins pass the same depth
	wire logic             start_w    = scl_s_q && scl_d_q && sda_d_q && !sda_s_q;
	wire logic             stop_w     = scl_s_q && scl_d_q && !sda_d_q && sda_s_q;
	wire logic             in_frame   = (state_q == ddi_pkg::BUS_FRAME);
	wire logic             load_mode  = stop_w && in_frame && done_s_q;
	wire logic             demo_d     = load_mode ? mode_s_q : demo_on_q;
	wire logic [COL_W-1:0] half_w     = i_px_width >> 1;
	wire logic             right_half = (i_px_col >= half_w);

	////////////////////////////////////////////////////////////////////////
	// Idle level of both pins is high, so no false edge follows reset
	always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			scl_meta_q <= 1'b1;
			scl_s_q    <= 1'b1;
			scl_d_q    <= 1'b1;
		end else begin
			scl_meta_q <= i_scl;
			scl_s_q    <= scl_meta_q;
			scl_d_q    <= scl_s_q;
		end
	end

	always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sda_meta_q <= 1'b1;
			sda_s_q    <= 1'b1;
			sda_d_q    <= 1'b1;
		end else begin
			sda_meta_q <= i_sda_i;
			sda_s_q    <= sda_meta_q;
			sda_d_q    <= sda_s_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Link flags are quiet long before STOP, so a plain two-stage copy is safe
	always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			done_meta_q <= 1'b0;
			done_s_q    <= 1'b0;
		end else begin
			done_meta_q <= link_done;
			done_s_q    <= done_meta_q;
		end
	end

	always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			mode_meta_q <= 1'b0;
			mode_s_q    <= 1'b0;
		end else begin
			mode_meta_q <= link_mode;
			mode_s_q    <= mode_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// A repeated START pulls the link back to its first byte
	always_comb begin
		state_d      = state_q;
		link_clr_n_d = 1'b0;
		unique case (state_q)
			ddi_pkg::BUS_IDLE: begin
				if (start_w) begin
					state_d = ddi_pkg::BUS_FRAME;
				end
			end
			ddi_pkg::BUS_FRAME: begin
				if (stop_w) begin
					state_d = ddi_pkg::BUS_IDLE;
				end else if (!start_w) begin
					link_clr_n_d = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= ddi_pkg::BUS_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Link reset leaves while the bus clock stands high, away from its edges
	always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			link_clr_n_q <= 1'b0;
		end else begin
			link_clr_n_q <= link_clr_n_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mode changes only on a STOP that closes a complete, matching frame
	always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			demo_on_q <= ddi_pkg::DEMO_RST;
		end else begin
			demo_on_q <= demo_d;
		end
	end

	// Registered against the column so the output comes from a flop
	always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			apply_q <= 1'b0;
		end else begin
			apply_q <= demo_on_q && right_half;
		end
	end

	// Open-drain pin only ever pulls low; the enable carries the data
	always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sda_o_q <= 1'b0;
		end else begin
			sda_o_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	ddi_link u_link (
		.i_scl      (i_scl),
		.i_clr_n    (link_clr_n_q),
		.i_sda      (i_sda_i),
		.o_sda_oe_n (link_oe_n),
		.o_done     (link_done),
		.o_mode_on  (link_mode)
	);

	assign o_sda_o      = sda_o_q;
	assign o_sda_oe_n   = link_oe_n;
	assign o_demo_on    = demo_on_q;
	assign o_demo_apply = apply_q;

	////////////////////////////////////////////////////////////////////////
	sequence s_stop_load;
		stop_w && in_frame && done_s_q;
	endsequence

	property p_demo_load;
		@(posedge i_clk_sys) disable iff (!rst_n_q)
		s_stop_load |=> (demo_on_q == $past(mode_s_q));
	endproperty
	a_demo_load: assert property (p_demo_load) else $error("Mode not taken at stop");

	property p_demo_keep;
		@(posedge i_clk_sys) disable iff (!rst_n_q)
		!(stop_w && in_frame && done_s_q) |=> $stable(demo_on_q);
	endproperty
	a_demo_keep: assert property (p_demo_keep) else $error("Mode moved without stop");

	property p_apply_left;
		@(posedge i_clk_sys) disable iff (!rst_n_q)
		!right_half |=> !apply_q;
	endproperty
	a_apply_left: assert property (p_apply_left) else $error("Demo applied on left half");

	property p_apply_right;
		@(posedge i_clk_sys) disable iff (!rst_n_q)
		right_half && demo_on_q |=> apply_q;
	endproperty
	a_apply_right: assert property (p_apply_right) else $error("Demo missing on right half");

endmodule

`default_nettype wire

//--- sim/ddi_master.sv
`timescale 1ns/100ps
`default_nettype none
module ddi_master (
	output var  logic o_scl,
	output var  logic o_sda_oe_n,
	input  wire logic i_sda
);
	int nacks = 0;
	initial begin
		o_scl = 1'b1;
		o_sda_oe_n = 1'b1;
	end
	// One bit; SDA moves only while SCL low
	task automatic bit1(input logic v, output logic s);
		#5;
		o_sda_oe_n = v;
		#80;
		o_scl = 1'b1;
		#20;
		s = i_sda;
		#20;
		o_scl = 1'b0;
	endtask
	// SCL stands high between frames
	task automatic frame(input logic [7:0] b[10]);
		logic s;
		o_sda_oe_n = 1'b0;
		#250;
		o_scl = 1'b0;
		for (int i = 0; i < 10; i++) begin
			for (int k = 7; k >= 0; k--) bit1(b[i][k], s);
			bit1(1'b1, s);
			if (s !== 1'b0) nacks++;
		end
		#5;
		o_sda_oe_n = 1'b0;
		#80;
		o_scl = 1'b1;
		#250;
		o_sda_oe_n = 1'b1;
		#500;
	endtask
endmodule
`default_nettype wire

//--- sim/ddi_demo_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ddi_demo_ctrl_tb;
	logic        clk_sys = 1'b0;
	logic        arst_n  = 1'b0;
	logic [11:0] px_col  = 12'h000;
	logic [11:0] px_w    = 12'h780;
	wire         scl, m_oe_n, d_o, d_oe_n, demo_on, demo_apply;
	wire         sda = m_oe_n & (d_oe_n | d_o);
	int          bad_count = 0;
	int          n_checks  = 0;
	int          seed      = 21;
	logic        q[$];
	logic [7:0]  b[10];
	event        chk;
	always #4 clk_sys = ~clk_sys;
	ddi_demo_ctrl uut (.i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_scl(scl),
		.i_sda_i(sda), .o_sda_o(d_o), .o_sda_oe_n(d_oe_n), .i_px_col(px_col),
		.i_px_width(px_w), .o_demo_on(demo_on), .o_demo_apply(demo_apply));
	ddi_master m (.o_scl(scl), .o_sda_oe_n(m_oe_n), .i_sda(sda));
	task automatic check(input logic e, input logic g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("Error %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic report_and_stop;
		if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Oldest expectation meets each settled result
	always @chk begin
		check(q[0], demo_on);
		check(q[0] && px_col >= 12'h3c0, demo_apply);
		void'(q.pop_front());
	end
	initial begin
		#400000;
		bad_count++;
		report_and_stop;
	end
	logic [7:0] t[7][3] = '{'{8'h00, 8'he0, 8'h01}, '{8'h00, 8'he0, 8'h00},
		'{8'h02, 8'h39, 8'h01}, '{8'h00, 8'he1, 8'h00}, '{8'h05, 8'h01, 8'h00},
		'{8'h04, 8'h15, 8'h00}, '{8'h09, 8'h01, 8'h00}};
	logic       e[7] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
	logic       v[7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
	initial begin
		repeat (16) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		for (int i = 0; i < 7; i++) begin
			b = '{8'he0, 8'h26, 8'h38, 8'h65, 8'h16, 8'h00, 8'h00, 8'h00, 8'h00, t[i][2]};
			b[t[i][0]] = t[i][1];
			@(posedge clk_sys) px_col <= 12'($random(seed));
			m.nacks = 0;
			m.frame(b);
			// Good frames fully acked, a bad byte is refused
			check(v[i], m.nacks == 0);
			q.push_back(e[i]);
			repeat (20) @(posedge clk_sys);
			#1;
			->chk;
		end
		#1;
		report_and_stop;
	end
endmodule
`default_nettype wire
